// file: hdl/spimc_host.sv
// module: wishbone-controlled host for the spi serial memory
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module spimc_host #(
    parameter int SECTOR_BYTES = spimc_pkg::SECTOR_BYTES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [spimc_pkg::ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_wdata,
    output logic [31:0] wb_rdata,
    output logic wb_ack,
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    output logic pause_n,
    output logic protect_pin_n
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_HIGH,
        ST_LOW,
        ST_LAG,
        ST_GAP
    } spimc_state_t;

    spimc_state_t state_q;
    logic [spimc_pkg::DIV_W-1:0] div_q;
    logic [2:0] bit_q;
    logic [5:0] byte_q;
    logic [5:0] last_q;
    logic [2:0] cmd_q;
    logic [4:0] rd_len_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] status_q;
    logic err_q;
    logic latch_known_q;
    logic pause_req_q;
    logic pause_n_q;
    logic sck_q;
    logic cs_n_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] buf_q [SECTOR_BYTES];

    logic so_s;
    logic acc;
    logic wr;
    logic [7:0] word_adr;
    logic start_wr;
    logic [2:0] cmd_in;
    logic [4:0] len_in;
    logic needs_latch;
    logic cmd_legal;
    logic launch;
    logic refuse;
    logic div_zero;
    logic high_end;
    logic byte_end;
    logic last_byte;
    logic frame_end;
    logic frozen;
    logic pause_ok;
    logic shift_load;
    logic shift_step;
    logic [7:0] load_data;
    logic [7:0] rx_byte;
    logic [31:0] rd_val;

    // so comes from another chip, so it is synchronised before use
    spimc_sync u_so_sync (
        .clock(clock),
        .rst(rst),
        .din(so),
        .dout(so_s)
    );

    spimc_shift u_shift (
        .clock(clock),
        .rst(rst),
        .load(shift_load),
        .load_data(load_data),
        .shift(shift_step),
        .in_bit(so_s),
        .out_bit(si),
        .rx_byte(rx_byte)
    );

    function automatic logic [7:0] op_of(input logic [2:0] c);
        case (c)
            spimc_pkg::CMD_LATCH_SET: op_of = spimc_pkg::OP_LATCH_SET;
            spimc_pkg::CMD_LATCH_CLR: op_of = spimc_pkg::OP_LATCH_CLR;
            spimc_pkg::CMD_STAT_RD: op_of = spimc_pkg::OP_STAT_RD;
            spimc_pkg::CMD_STAT_WR: op_of = spimc_pkg::OP_STAT_WR;
            spimc_pkg::CMD_ARR_RD: op_of = spimc_pkg::OP_ARR_RD;
            spimc_pkg::CMD_ARR_PROG: op_of = spimc_pkg::OP_ARR_PROG;
            default: op_of = spimc_pkg::OP_STAT_RD;
        endcase
    endfunction

    // index of the final byte of the frame; chip select rises LAG_CYC cycles after it
    function automatic logic [5:0] last_of(input logic [2:0] c, input logic [4:0] n);
        case (c)
            spimc_pkg::CMD_STAT_RD: last_of = 6'h01;
            spimc_pkg::CMD_STAT_WR: last_of = 6'h01;
            spimc_pkg::CMD_ARR_RD: last_of = 6'(spimc_pkg::HDR_BYTES) + {1'b0, n};
            spimc_pkg::CMD_ARR_PROG: last_of = 6'(spimc_pkg::HDR_BYTES + SECTOR_BYTES - 1);
            default: last_of = 6'h00;
        endcase
    endfunction

    function automatic logic [7:0] tx_byte(input logic [5:0] b);
        logic [4:0] idx;
        idx = 5'(b - 6'(spimc_pkg::HDR_BYTES));
        if (cmd_q == spimc_pkg::CMD_STAT_WR) begin
            tx_byte = wdata_q & spimc_pkg::STAT_WR_MASK;
        end else if (b == 6'h01) begin
            tx_byte = addr_q[15:8];
        end else if (b == 6'h02 && cmd_q == spimc_pkg::CMD_ARR_PROG) begin
            tx_byte = addr_q[7:0] & spimc_pkg::SECTOR_MASK;
        end else if (b == 6'h02) begin
            tx_byte = addr_q[7:0];
        end else if (cmd_q == spimc_pkg::CMD_ARR_PROG) begin
            tx_byte = buf_q[idx];
        end else begin
            tx_byte = 8'h00;
        end
    endfunction

    // bus decode; one ack per request, dropped the cycle after
    assign acc = wb_cyc && wb_stb && !ack_q;
    assign wr = acc && wb_we;
    assign word_adr = {wb_adr[7:2], 2'b00};
    assign start_wr = wr && word_adr == spimc_pkg::REG_CTRL && wb_sel[0]
        && wb_wdata[spimc_pkg::CTRL_START_BIT];
    assign cmd_in = wb_wdata[2:0];
    assign len_in = wb_wdata[spimc_pkg::CTRL_LEN_LSB +: 5];
    assign cmd_legal = cmd_in <= spimc_pkg::CMD_ARR_PROG;
    assign needs_latch = cmd_in == spimc_pkg::CMD_ARR_PROG || cmd_in == spimc_pkg::CMD_STAT_WR;
    assign refuse = start_wr && (state_q != ST_IDLE || !cmd_legal || (needs_latch && !latch_known_q));
    assign launch = start_wr && !refuse;

    assign div_zero = div_q == '0;
    assign high_end = state_q == ST_HIGH && div_zero;
    assign byte_end = high_end && bit_q == 3'h7;
    assign last_byte = byte_q == last_q;
    assign frame_end = state_q == ST_LAG && div_zero;
    assign frozen = pause_req_q || !pause_n_q;
    // pause may move only where sck is low now and will not rise this edge
    assign pause_ok = state_q == ST_IDLE || state_q == ST_LAG || state_q == ST_GAP
        || ((state_q == ST_LOW || state_q == ST_LEAD) && !div_zero);

    assign shift_load = launch || (byte_end && !last_byte);
    assign shift_step = high_end && !shift_load;
    assign load_data = launch ? op_of(cmd_in) : tx_byte(6'(byte_q + 6'h01));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            div_q <= '0;
            bit_q <= 3'h0;
            byte_q <= 6'h00;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (launch) begin
                        state_q <= ST_LEAD;
                        cs_n_q <= 1'b0;
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::LEAD_CYC - 1);
                        bit_q <= 3'h0;
                        byte_q <= 6'h00;
                    end
                end
                ST_LEAD: begin
                    // a pause before the first rise must hold sck low too, or the device loses bit 7
                    if (frozen) begin
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::LEAD_CYC - 1);
                    end else if (div_zero) begin
                        state_q <= ST_HIGH;
                        sck_q <= 1'b1;
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::HALF_CYC - 1);
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (div_zero) begin
                        sck_q <= 1'b0;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7 && last_byte) begin
                            state_q <= ST_LAG;
                            div_q <= spimc_pkg::DIV_W'(spimc_pkg::LAG_CYC - 1);
                        end else begin
                            state_q <= ST_LOW;
                            div_q <= spimc_pkg::DIV_W'(spimc_pkg::HALF_CYC - 1);
                        end
                        if (bit_q == 3'h7 && !last_byte) begin
                            byte_q <= byte_q + 6'h01;
                        end
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                ST_LOW: begin
                    // a pause restarts the low half, so sck stays low a full half after release
                    if (frozen) begin
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::HALF_CYC - 1);
                    end else if (div_zero) begin
                        state_q <= ST_HIGH;
                        sck_q <= 1'b1;
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::HALF_CYC - 1);
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                ST_LAG: begin
                    if (div_zero) begin
                        state_q <= ST_GAP;
                        cs_n_q <= 1'b1;
                        div_q <= spimc_pkg::DIV_W'(spimc_pkg::GAP_CYC - 1);
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (div_zero) begin
                        state_q <= ST_IDLE;
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cs_n_q <= 1'b1;
                    sck_q <= 1'b0;
                end
            endcase
        end
    end

    // command latch, taken only when a frame launches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_q <= spimc_pkg::CMD_LATCH_SET;
            rd_len_q <= spimc_pkg::RD_LEN_RST;
            last_q <= 6'h00;
        end else if (launch) begin
            cmd_q <= cmd_in;
            rd_len_q <= len_in;
            last_q <= last_of(cmd_in, len_in);
        end
    end

    // software-written operands and pin levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_q <= spimc_pkg::ADDR_RST;
            wdata_q <= 8'h00;
            protect_pin_n <= spimc_pkg::PROT_PIN_RST;
            pause_req_q <= spimc_pkg::PAUSE_REQ_RST;
        end else if (wr) begin
            if (word_adr == spimc_pkg::REG_ADDR && wb_sel[0] && state_q == ST_IDLE) begin
                addr_q[7:0] <= wb_wdata[7:0];
            end
            if (word_adr == spimc_pkg::REG_ADDR && wb_sel[1] && state_q == ST_IDLE) begin
                addr_q[15:8] <= wb_wdata[15:8];
            end
            if (word_adr == spimc_pkg::REG_WDATA && wb_sel[0] && state_q == ST_IDLE) begin
                wdata_q <= wb_wdata[7:0];
            end
            // the pin level is free to change; the device judges it itself
            if (word_adr == spimc_pkg::REG_PINS && wb_sel[0]) begin
                protect_pin_n <= wb_wdata[0];
                pause_req_q <= wb_wdata[spimc_pkg::PINS_PAUSE_BIT];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pause_n_q <= 1'b1;
        end else if (pause_ok) begin
            pause_n_q <= !pause_req_q;
        end
    end

    // refusal flag: a new refusal beats a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (refuse) begin
            err_q <= 1'b1;
        end else if (wr && word_adr == spimc_pkg::REG_STAT && wb_sel[0] && wb_wdata[spimc_pkg::STAT_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // host view of the latch, mirrors what the device does after each frame
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_known_q <= 1'b0;
        end else if (frame_end) begin
            if (cmd_q == spimc_pkg::CMD_LATCH_SET) begin
                latch_known_q <= 1'b1;
            end else if (cmd_q != spimc_pkg::CMD_STAT_RD && cmd_q != spimc_pkg::CMD_ARR_RD) begin
                latch_known_q <= 1'b0;
            end
        end
    end

    // the status byte is kept raw; busy and latch decoding is software's
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= spimc_pkg::STATUS_RST;
        end else if (byte_end && cmd_q == spimc_pkg::CMD_STAT_RD && byte_q == 6'h01) begin
            status_q <= rx_byte;
        end
    end

    // sector buffer: program source and read landing area; bus writes only while idle
    always_ff @(posedge clock) begin
        if (byte_end && cmd_q == spimc_pkg::CMD_ARR_RD && byte_q >= 6'(spimc_pkg::HDR_BYTES)) begin
            buf_q[5'(byte_q - 6'(spimc_pkg::HDR_BYTES))] <= rx_byte;
        end else if (wr && wb_adr[7] && wb_sel[0] && state_q == ST_IDLE) begin
            buf_q[wb_adr[6:2]] <= wb_wdata[7:0];
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (wb_adr[7]) begin
            rd_val = {24'h00_0000, buf_q[wb_adr[6:2]]};
        end else begin
            case (word_adr)
                spimc_pkg::REG_CTRL: rd_val = {19'h0_0000, rd_len_q, 5'h00, cmd_q};
                spimc_pkg::REG_ADDR: rd_val = {16'h0000, addr_q};
                spimc_pkg::REG_WDATA: rd_val = {24'h00_0000, wdata_q};
                spimc_pkg::REG_STAT: rd_val = {16'h0000, status_q, 5'h00, latch_known_q, err_q, state_q != ST_IDLE};
                spimc_pkg::REG_PINS: rd_val = {29'h0000_0000, !pause_n_q, pause_req_q, protect_pin_n};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc && !wb_we) begin
                rdata_q <= rd_val;
            end
        end
    end

    assign wb_ack = ack_q;
    assign wb_rdata = rdata_q;
    assign sck = sck_q;
    assign cs_n = cs_n_q;
    assign pause_n = pause_n_q;

    // helper: bits sent and rising edges seen in the current frame
    logic [7:0] sent_q;
    logic [8:0] rise_cnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sent_q <= 8'h00;
            rise_cnt_q <= 9'h000;
        end else begin
            if (!sck_q && (state_q == ST_LEAD || state_q == ST_LOW) && div_zero && !frozen) begin
                sent_q <= {sent_q[6:0], si};
                rise_cnt_q <= rise_cnt_q + 9'h001;
            end
            if (launch) begin
                rise_cnt_q <= 9'h000;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_PAUSE_SCK_LOW: assert property ($changed(pause_n) |-> !sck && !$past(sck))
        else $error("pause changed while sck was not low");
    AST_CS_LEAD: assert property ($fell(cs_n) |-> (!sck && !cs_n) [*8])
        else $error("sck moved too soon after chip select fell");
    AST_SI_STABLE: assert property (sck |-> $stable(si))
        else $error("si changed while sck was high");
    AST_OPCODE_SENT: assert property (byte_end && byte_q == 6'h00 |-> sent_q == op_of(cmd_q))
        else $error("opcode on si differs from command");
    AST_STATWR_MASK: assert property (byte_end && byte_q == 6'h01 && cmd_q == spimc_pkg::CMD_STAT_WR
        |-> (sent_q & ~spimc_pkg::STAT_WR_MASK) == 8'h00)
        else $error("status write data has reserved bits set");
    AST_PROG_LATCH: assert property ($fell(cs_n) && (cmd_q == spimc_pkg::CMD_ARR_PROG
        || cmd_q == spimc_pkg::CMD_STAT_WR) |-> $past(latch_known_q))
        else $error("program frame started without the latch set");
    AST_PROG_280: assert property ($rose(cs_n) && cmd_q == spimc_pkg::CMD_ARR_PROG |-> rise_cnt_q == 9'd280)
        else $error("program frame did not carry exactly 35 bytes");
    AST_LATCH_8: assert property ($rose(cs_n) && cmd_q == spimc_pkg::CMD_LATCH_SET |-> rise_cnt_q == 9'd8)
        else $error("latch set frame not ended after eight bits");
    AST_READ_LEN: assert property ($rose(cs_n) && cmd_q == spimc_pkg::CMD_ARR_RD
        |-> rise_cnt_q == 9'd32 + {1'b0, rd_len_q, 3'h0})
        else $error("read frame length differs from request");
    AST_CS_RISE_SCK_LOW: assert property ($rose(cs_n) |-> !$past(sck) && !$past(sck, 8))
        else $error("chip select rose too soon after sck");

    COV_PROG_DONE: cover property ($rose(cs_n) && cmd_q == spimc_pkg::CMD_ARR_PROG);
    COV_PAUSE_MID: cover property (!cs_n && $fell(pause_n));
    COV_READ_DONE: cover property ($rose(cs_n) && cmd_q == spimc_pkg::CMD_ARR_RD);
endmodule

// file: include/spimc_pkg.sv
// package: constants and register map of the spi memory host controller
package spimc_pkg;
    localparam int CLK_NS = 40;
    localparam int SCK_HALF_NS = 500;
    localparam int CS_LEAD_NS = 500;
    localparam int CS_LAG_NS = 500;
    localparam int CS_GAP_NS = 2000;
    localparam int HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int LEAD_CYC = (CS_LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int LAG_CYC = (CS_LAG_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIV_W = 12;
    localparam int SECTOR_BYTES = 32;
    localparam int HDR_BYTES = 3;
    localparam int ADR_W = 8;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_PROG = 8'h02;
    localparam logic [2:0] CMD_LATCH_SET = 3'h0;
    localparam logic [2:0] CMD_LATCH_CLR = 3'h1;
    localparam logic [2:0] CMD_STAT_RD = 3'h2;
    localparam logic [2:0] CMD_STAT_WR = 3'h3;
    localparam logic [2:0] CMD_ARR_RD = 3'h4;
    localparam logic [2:0] CMD_ARR_PROG = 3'h5;
    localparam logic [7:0] STAT_WR_MASK = 8'h8c;
    localparam logic [7:0] SECTOR_MASK = 8'he0;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_PINS = 8'h10;
    localparam logic [7:0] REG_BUF = 8'h80;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_LEN_LSB = 8;
    localparam int STAT_ERR_BIT = 1;
    localparam int PINS_PAUSE_BIT = 1;
    localparam logic PROT_PIN_RST = 1'b1;
    localparam logic PAUSE_REQ_RST = 1'b0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [4:0] RD_LEN_RST = 5'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;
endpackage

// file: hdl/spimc_sync.sv
// module: two-flop synchroniser for one pin input
`timescale 1ns/1ps
module spimc_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// file: hdl/spimc_shift.sv
// module: byte shift register, msb first out and in
`timescale 1ns/1ps
module spimc_shift (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [7:0] load_data,
    input wire logic shift,
    input wire logic in_bit,
    output logic out_bit,
    output logic [7:0] rx_byte
);
    logic [7:0] sh_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_q <= 8'h00;
        end else if (load) begin
            sh_q <= load_data;
        end else if (shift) begin
            sh_q <= {sh_q[6:0], in_bit};
        end
    end

    assign out_bit = sh_q[7];
    assign rx_byte = {sh_q[6:0], in_bit};
endmodule

// file: verif/spimc_mem_model.sv
// behavioural serial memory device facing the host
`timescale 1ns/1ps
module spimc_mem_model #(
    parameter int BUSY_NS = 20000,
    parameter int TOP_BIT = 12 // top array address bit; the array size here is arbitrary
) (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic pause_n,
    input wire logic protect_pin_n,
    output logic so
);
    logic [7:0] sh = 8'h00, op = 8'h00, tx = 8'h00, wb = 8'h00;
    logic [15:0] adr = 16'h0000;
    logic latch = 1'b0;
    logic busy = 1'b0;
    logic go = 1'b0;
    logic pe = 1'b0;
    logic [1:0] bl = 2'h0;
    // one sector of storage, seen again at every sector of the array
    logic [7:0] pg [32] = '{default: 8'h00};
    logic [7:0] pw [32];
    int bc = 0, nb = 0;
    initial so = 1'b0;
    function automatic logic [7:0] stat();
        return busy ? 8'hff : {pe, 3'h0, bl, latch, busy};
    endfunction
    function automatic logic locked();
        return bl == 2'h3 || (bl == 2'h2 && adr[TOP_BIT]) || (bl == 2'h1 && &adr[TOP_BIT -: 2]);
    endfunction
    always @(negedge cs_n) begin
        bc = 0;
        nb = 0;
    end
    // pause freezes the bit and byte counters in place
    always @(posedge sck) if (!cs_n && pause_n) begin
        sh = {sh[6:0], si};
        bc++;
        if (bc == 8) begin
            bc = 0;
            if (nb == 0) op = sh;
            if (nb == 1) adr[15:8] = sh;
            if (nb == 1) wb = sh;
            if (nb == 2) adr[7:0] = sh;
            // an unaligned start address would rotate the data inside the sector
            if (op == 8'h02 && nb > 2 && nb < 35) pw[5'(adr[4:0] + nb - 3)] = sh;
            nb++;
            if (op == 8'h05) tx = stat();
            if (op == 8'h03 && nb >= 3) begin
                tx = pg[adr[4:0]] ^ adr[7:0] ^ adr[15:8];
                adr++;
            end
        end
    end
    always @(negedge sck) if (!cs_n && pause_n) begin
        so = tx[7];
        tx = {tx[6:0], ~tx[0]};
    end
    // commits only on a whole command; a stray extra bit cancels it
    always @(posedge cs_n) begin
        so = ~so;
        go = 1'b0;
        if (bc == 0 && nb == 1 && op == 8'h06) latch = 1'b1;
        if (bc == 0 && nb == 1 && op == 8'h04) latch = 1'b0;
        if (bc == 0 && nb == 2 && op == 8'h01 && latch && !(pe && !protect_pin_n)) begin
            pe = wb[7];
            bl = wb[3:2];
            go = 1'b1;
        end
        if (bc == 0 && nb == 35 && op == 8'h02 && latch && !locked()) begin
            pg = pw;
            go = 1'b1;
        end
        // delayed so that status reads during the cycle still see busy
        if (go) begin
            busy = 1'b1;
            busy <= #(BUSY_NS) 1'b0;
            latch <= #(BUSY_NS) 1'b0;
        end
    end
endmodule

// file: verif/test_spimc_host.sv
// self-checking bench for the spi memory host controller
`timescale 1ns/1ps
module test_spimc_host;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic ack, sck, cs_n, si, so, pause_n, prot_n;
    logic [8:0] expq[$];
    logic [8:0] e;
    logic [7:0] pd [32];
    logic [15:0] ra, a2;
    int n_fail = 0, check_count = 0, cyc_n = 0;
    always #20 clock = ~clock;
    spimc_host i_spimc_host (.clock(clock), .rst(rst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(4'hf), .wb_wdata(wdata), .wb_rdata(rdata), .wb_ack(ack), .sck(sck),
        .cs_n(cs_n), .si(si), .so(so), .pause_n(pause_n), .protect_pin_n(prot_n));
    spimc_mem_model u_mem (.sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
        .protect_pin_n(prot_n), .so(so));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD rdata byte exp %h got %h", exp, got);
        end
    endtask
    always @(posedge clock) if (ack && !we && chk) begin
        e = expq.pop_front();
        cmp(e[7:0], e[8] ? rdata[15:8] : rdata[7:0]);
    end
    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdata <= d;
        chk <= c;
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        rd = rdata;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk <= 1'b0;
        @(posedge clock);
    endtask
    // start a frame, then poll the engine busy bit
    task automatic op(input logic [2:0] c, input logic [4:0] len, input logic hold = 1'b0);
        bus(1'b1, spimc_pkg::REG_CTRL, {19'h0, len, 4'h0, 1'b1, c}, 1'b0);
        // pause in mid-frame, then release
        if (hold) begin
            repeat (300) @(posedge clock);
            bus(1'b1, spimc_pkg::REG_PINS, 32'h2, 1'b0);
            repeat (200) @(posedge clock);
            bus(1'b1, spimc_pkg::REG_PINS, 32'h0, 1'b0);
        end
        do bus(1'b0, spimc_pkg::REG_STAT, 32'h0, 1'b0); while (rd[0] !== 1'b0);
    endtask
    task automatic sread(input logic [7:0] exp, input logic c);
        op(3'h2, 5'h0);
        if (c) expq.push_back({1'b1, exp});
        bus(1'b0, spimc_pkg::REG_STAT, 32'h0, c);
    endtask
    initial begin
        void'($urandom(32'h3440));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        op(3'h0, 5'h0);
        sread(8'h02, 1'b1);
        $display("test latch done");
        for (int k = 0; k < 32; k++) begin
            pd[k] = 8'($urandom);
            bus(1'b1, spimc_pkg::REG_BUF + 8'(4 * k), {24'h0, pd[k]}, 1'b0);
        end
        bus(1'b1, spimc_pkg::REG_ADDR, $urandom, 1'b0);
        op(3'h5, 5'h0);
        sread(8'hff, 1'b1);
        do sread(8'h00, 1'b0); while (rd[8] !== 1'b0);
        sread(8'h00, 1'b1);
        bus(1'b1, spimc_pkg::REG_CTRL, 32'hd, 1'b0);
        expq.push_back(9'h002);
        bus(1'b0, spimc_pkg::REG_STAT, 32'h0, 1'b1);
        bus(1'b1, spimc_pkg::REG_STAT, 32'h2, 1'b0);
        expq.push_back(9'h000);
        bus(1'b0, spimc_pkg::REG_STAT, 32'h0, 1'b1);
        $display("test program done");
        op(3'h0, 5'h0);
        bus(1'b1, spimc_pkg::REG_WDATA, 32'h8c, 1'b0);
        op(3'h3, 5'h0);
        sread(8'hff, 1'b1);
        do sread(8'h00, 1'b0); while (rd[8] !== 1'b0);
        sread(8'h8c, 1'b1);
        $display("test status write done");
        bus(1'b1, spimc_pkg::REG_PINS, 32'h0, 1'b0);
        op(3'h0, 5'h0);
        bus(1'b1, spimc_pkg::REG_WDATA, 32'h0, 1'b0);
        op(3'h3, 5'h0);
        sread(8'h8e, 1'b1);
        op(3'h1, 5'h0);
        sread(8'h8c, 1'b1);
        op(3'h0, 5'h0);
        op(3'h5, 5'h0);
        sread(8'h8e, 1'b1);
        $display("test protect done");
        for (int i = 0; i < 2; i++) begin
            ra = i ? 16'($urandom) : 16'hffff;
            bus(1'b1, spimc_pkg::REG_ADDR, {16'h0, ra}, 1'b0);
            op(3'h4, 5'h1, i == 1);
            for (int j = 0; j < 2; j++) begin
                a2 = ra + 16'(j);
                expq.push_back({1'b0, pd[a2[4:0]] ^ a2[7:0] ^ a2[15:8]});
                bus(1'b0, spimc_pkg::REG_BUF + 8'(4 * j), 32'h0, 1'b1);
            end
        end
        $display("test array read done");
        tally_and_finish();
    end
endmodule
